// ---- hdl/fbdp_defines.svh ----
// Purpose: shared constants of the frame buffer display path
// Assumes: 250 MHz core clock, word-wide asynchronous SRAM
// Notes:   register offsets are byte addresses on the plain port
`ifndef FBDP_DEFINES_SVH
`define FBDP_DEFINES_SVH

// ----------------------------------------------------------------
// memory geometry
// ----------------------------------------------------------------
`define FBDP_ADDR_W      18
`define FBDP_DATA_W      16
`define FBDP_OFS_W       17
`define FBDP_PAGE_WORDS  18'h12C00
`define FBDP_OFS_LAST    17'h12BFF
`define FBDP_PAGE_COUNT  2'h3

// ----------------------------------------------------------------
// register map and fields
// ----------------------------------------------------------------
`define FBDP_REG_CTRL    4'h0
`define FBDP_REG_DADDR   4'h4
`define FBDP_REG_DDATA   4'h8
`define FBDP_REG_STATUS  4'hC
`define FBDP_CTRL_MIRROR 0
`define FBDP_CTRL_FLIP   1
`define FBDP_CTRL_DPAGE  2
`define FBDP_CTRL_WPAGE  4
`define FBDP_ST_PEND     0
`define FBDP_ST_ACTIVE   1
`define FBDP_ST_REQ      2
`define FBDP_ST_POL      3
`define FBDP_MIRROR_RST  1'b0
`define FBDP_FLIP_RST    1'b1
`define FBDP_PAGE_RST    2'h0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define FBDP_CLK_NS      4
`define FBDP_T_WP_NS     10
`define FBDP_WP_CYC      ((`FBDP_T_WP_NS + `FBDP_CLK_NS - 1) / `FBDP_CLK_NS)
`define FBDP_SYNC_DEPTH  3
`define FBDP_MIN_DOT_DIV 8

`endif

// ---- hdl/fbdp_pkg.sv ----
// Purpose: types of the frame buffer display path
// Assumes: constants come from fbdp_defines.svh
// Notes:   write sequencer states only
package fbdp_pkg;

  // ----------------------------------------------------------------
  // drawing write sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FBDP_WS_IDLE,
    FBDP_WS_SETUP,
    FBDP_WS_PULSE,
    FBDP_WS_HOLD
  } fbdp_wr_state_t;

endpackage

// ---- hdl/fbdp_timing.sv ----
// Purpose: dot, line and frame timing for the panel
// Assumes: one dot lasts DOT_DIV core clocks
// Notes:   all outputs registered, aligned to the current dot
`timescale 1ns/1ps
module fbdp_timing
  import fbdp_pkg::*;
#(
  parameter int H_ACT   = 320,
  parameter int H_FP    = 20,
  parameter int H_SYNC  = 30,
  parameter int H_BP    = 38,
  parameter int V_ACT   = 240,
  parameter int V_FP    = 4,
  parameter int V_SYNC  = 3,
  parameter int V_BP    = 15,
  parameter int DOT_DIV = 40
)
(
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  output logic      o_tick,
  output logic      o_dot_hi,
  output logic      o_hsync_b,
  output logic      o_vsync_b,
  output logic      o_active,
  output logic      o_write_ok,
  output logic      o_frame
);

  localparam int H_TOT = H_ACT + H_FP + H_SYNC + H_BP;
  localparam int V_TOT = V_ACT + V_FP + V_SYNC + V_BP;

  logic [7:0] div_reg, div_next;
  logic [9:0] h_reg, h_next;
  logic [9:0] v_reg, v_next;
  logic       tick_next, hi_next, hs_next, vs_next;
  logic       act_next, wok_next, frm_next, nxt_line_vis;

  // ----------------------------------------------------------------
  // next counters and decoded dot state
  // ----------------------------------------------------------------
  always_comb
  begin
    div_next  = div_reg + 8'h01;
    h_next    = h_reg;
    v_next    = v_reg;
    tick_next = 1'b0;
    if (div_reg == 8'(DOT_DIV - 1))
    begin
      div_next  = 8'h00;
      tick_next = 1'b1;
      h_next    = h_reg + 10'h001;
      if (h_reg == 10'(H_TOT - 1))
      begin
        h_next = 10'h000;
        v_next = (v_reg == 10'(V_TOT - 1)) ? 10'h000 : v_reg + 10'h001;
      end
    end
    hi_next  = (div_next < 8'(DOT_DIV / 2));
    hs_next  = !((h_next >= 10'(H_ACT + H_FP)) &&
                 (h_next <  10'(H_ACT + H_FP + H_SYNC)));
    vs_next  = !((v_next >= 10'(V_ACT + V_FP)) &&
                 (v_next <  10'(V_ACT + V_FP + V_SYNC)));
    act_next = (h_next < 10'(H_ACT)) && (v_next < 10'(V_ACT));
    nxt_line_vis = (v_next == 10'(V_TOT - 1)) ||
                   (v_next < 10'(V_ACT - 1));
    // blank dot whose successor is blank too
    wok_next = !act_next &&
               !((h_next == 10'(H_TOT - 1)) && nxt_line_vis);
    frm_next = tick_next && (h_next == 10'h000) && (v_next == 10'h000);
  end

  // ----------------------------------------------------------------
  // timing registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      div_reg    <= 8'h00;
      h_reg      <= 10'h000;
      v_reg      <= 10'h000;
      o_tick     <= 1'b0;
      o_dot_hi   <= 1'b0;
      o_hsync_b  <= 1'b1;
      o_vsync_b  <= 1'b1;
      o_active   <= 1'b0;
      o_write_ok <= 1'b0;
      o_frame    <= 1'b0;
    end
    else
    begin
      div_reg    <= div_next;
      h_reg      <= h_next;
      v_reg      <= v_next;
      o_tick     <= tick_next;
      o_dot_hi   <= hi_next;
      o_hsync_b  <= hs_next;
      o_vsync_b  <= vs_next;
      o_active   <= act_next;
      o_write_ok <= wok_next;
      o_frame    <= frm_next;
    end
  end

endmodule

// ---- hdl/fbdp_top.sv ----
// Purpose: frame buffer sram sequencer and panel drive
// Assumes: sram is asynchronous, 10 ns class; panel samples the data bus
// Notes:   display reads lag the period output by the request sync delay
`timescale 1ns/1ps
`include "fbdp_defines.svh"
module fbdp_top
  import fbdp_pkg::*;
#(
  parameter int H_ACT   = 320,
  parameter int H_FP    = 20,
  parameter int H_SYNC  = 30,
  parameter int H_BP    = 38,
  parameter int V_ACT   = 240,
  parameter int V_FP    = 4,
  parameter int V_SYNC  = 3,
  parameter int V_BP    = 15,
  parameter int DOT_DIV = 40
)
(
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_b,
  // register port
  input  wire logic [3:0]               i_addr,
  input  wire logic [31:0]              i_wdata,
  input  wire logic                     i_wr,
  input  wire logic                     i_rd,
  output logic      [31:0]              o_rdata,
  // frame buffer sram
  output logic      [`FBDP_ADDR_W-1:0]  o_fb_word_addr,
  input  wire logic [`FBDP_DATA_W-1:0]  i_fb_data_bus,
  output logic      [`FBDP_DATA_W-1:0]  o_fb_data_bus,
  output logic                          o_fb_data_oe_b,
  output logic                          o_fb_cs_b,
  output logic                          o_fb_rd_b,
  output logic                          o_fb_wr_b,
  output logic                          o_fb_ctl_oe_b,
  input  wire logic                     i_display_xfer_req,
  output logic                          o_display_period_out,
  // panel
  output logic                          o_dot_clk,
  output logic                          o_hsync_b,
  output logic                          o_vsync_b,
  output logic                          o_pixel_valid,
  output logic                          o_hmirror,
  output logic                          o_vflip,
  input  wire logic                     i_dot_clk_pol_sel
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  localparam int WP_CYC = `FBDP_WP_CYC;
  initial
  begin
    if (DOT_DIV < `FBDP_MIN_DOT_DIV || DOT_DIV > 255)
      $error("DOT_DIV cannot hold a whole write cycle in one dot");
    if (H_ACT * V_ACT > int'(`FBDP_PAGE_WORDS))
      $error("active area larger than one page");
    if (WP_CYC + 2 > DOT_DIV)
      $error("write pulse longer than a dot");
  end

  // ----------------------------------------------------------------
  // timing generator
  // ----------------------------------------------------------------
  logic tm_tick, tm_hi, tm_hs_b, tm_vs_b, tm_act, tm_wok, tm_frame;

  fbdp_timing #(
    .H_ACT   (H_ACT),
    .H_FP    (H_FP),
    .H_SYNC  (H_SYNC),
    .H_BP    (H_BP),
    .V_ACT   (V_ACT),
    .V_FP    (V_FP),
    .V_SYNC  (V_SYNC),
    .V_BP    (V_BP),
    .DOT_DIV (DOT_DIV)
  ) u_timing (
    .i_clk      (i_clk),
    .i_rst_b    (i_rst_b),
    .o_tick     (tm_tick),
    .o_dot_hi   (tm_hi),
    .o_hsync_b  (tm_hs_b),
    .o_vsync_b  (tm_vs_b),
    .o_active   (tm_act),
    .o_write_ok (tm_wok),
    .o_frame    (tm_frame)
  );

  // ----------------------------------------------------------------
  // pin synchronisers: request and polarity select
  // ----------------------------------------------------------------
  logic [1:0] pin_in;
  logic [1:0] filt_reg;
  assign pin_in = {i_dot_clk_pol_sel, i_display_xfer_req};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_sync
      logic [`FBDP_SYNC_DEPTH-1:0] sh_reg, sh_next;
      logic                        f_next;
      // shift, then accept once the last two stages agree
      always_comb
      begin
        sh_next = {sh_reg[`FBDP_SYNC_DEPTH-2:0], pin_in[gi]};
        f_next  = filt_reg[gi];
        if (sh_reg[2] == sh_reg[1])
          f_next = sh_reg[1];
      end
      always_ff @(posedge i_clk or negedge i_rst_b)
      begin
        if (!i_rst_b)
        begin
          sh_reg       <= '0;
          filt_reg[gi] <= (gi == 1); // polarity pin idles high
        end
        else
        begin
          sh_reg       <= sh_next;
          filt_reg[gi] <= f_next;
        end
      end
    end
  endgenerate

  logic req_f, pol_f;
  assign req_f = filt_reg[0];
  assign pol_f = filt_reg[1];

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic                   mirror_reg, mirror_next;
  logic                   flip_reg, flip_next;
  logic [1:0]             dpage_reg, dpage_next;
  logic [1:0]             wpage_reg, wpage_next;
  logic [1:0]             dlive_reg, dlive_next;
  logic [`FBDP_OFS_W-1:0] dofs_reg, dofs_next;
  logic [`FBDP_DATA_W-1:0] ddata_reg, ddata_next;
  logic                   pend_reg, pend_next;
  logic [31:0]            rdata_next;
  logic                   wr_done;
  logic [1:0]             pg_dp, pg_wp;

  // register writes, readback and draw request latch
  always_comb
  begin
    mirror_next = mirror_reg;
    flip_next   = flip_reg;
    dpage_next  = dpage_reg;
    wpage_next  = wpage_reg;
    dofs_next   = dofs_reg;
    ddata_next  = ddata_reg;
    pend_next   = pend_reg;
    dlive_next  = tm_frame ? dpage_reg : dlive_reg;
    rdata_next  = 32'h0000_0000;
    pg_dp       = i_wdata[`FBDP_CTRL_DPAGE +: 2];
    pg_wp       = i_wdata[`FBDP_CTRL_WPAGE +: 2];
    if (wr_done)
    begin
      pend_next = 1'b0;
      dofs_next = (dofs_reg == `FBDP_OFS_LAST) ? '0
                                               : dofs_reg + 1'b1;
    end
    if (i_wr)
    begin
      if (i_addr == `FBDP_REG_CTRL)
      begin
        mirror_next = i_wdata[`FBDP_CTRL_MIRROR];
        flip_next   = i_wdata[`FBDP_CTRL_FLIP];
        if (pg_dp < `FBDP_PAGE_COUNT)
          dpage_next = pg_dp;
        if (pg_wp < `FBDP_PAGE_COUNT)
          wpage_next = pg_wp;
      end
      else if (i_addr == `FBDP_REG_DADDR && !pend_reg)
      begin
        if (i_wdata[`FBDP_OFS_W-1:0] <= `FBDP_OFS_LAST)
          dofs_next = i_wdata[`FBDP_OFS_W-1:0];
      end
      else if (i_addr == `FBDP_REG_DDATA && !pend_reg)
      begin
        ddata_next = i_wdata[`FBDP_DATA_W-1:0];
        pend_next  = 1'b1;
      end
    end
    if (i_rd)
    begin
      if (i_addr == `FBDP_REG_CTRL)
      begin
        rdata_next[`FBDP_CTRL_MIRROR]   = mirror_reg;
        rdata_next[`FBDP_CTRL_FLIP]     = flip_reg;
        rdata_next[`FBDP_CTRL_DPAGE +: 2] = dpage_reg;
        rdata_next[`FBDP_CTRL_WPAGE +: 2] = wpage_reg;
      end
      else if (i_addr == `FBDP_REG_DADDR)
        rdata_next[`FBDP_OFS_W-1:0] = dofs_reg;
      else if (i_addr == `FBDP_REG_DDATA)
        rdata_next[`FBDP_DATA_W-1:0] = ddata_reg;
      else if (i_addr == `FBDP_REG_STATUS)
      begin
        rdata_next[`FBDP_ST_PEND]   = pend_reg;
        rdata_next[`FBDP_ST_ACTIVE] = tm_act;
        rdata_next[`FBDP_ST_REQ]    = req_f;
        rdata_next[`FBDP_ST_POL]    = pol_f;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      mirror_reg <= `FBDP_MIRROR_RST;
      flip_reg   <= `FBDP_FLIP_RST;
      dpage_reg  <= `FBDP_PAGE_RST;
      wpage_reg  <= `FBDP_PAGE_RST;
      dlive_reg  <= `FBDP_PAGE_RST;
      dofs_reg   <= '0;
      ddata_reg  <= '0;
      pend_reg   <= 1'b0;
      o_rdata    <= 32'h0000_0000;
    end
    else
    begin
      mirror_reg <= mirror_next;
      flip_reg   <= flip_next;
      dpage_reg  <= dpage_next;
      wpage_reg  <= wpage_next;
      dlive_reg  <= dlive_next;
      dofs_reg   <= dofs_next;
      ddata_reg  <= ddata_next;
      pend_reg   <= pend_next;
      o_rdata    <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // sram sequencer: display reads and drawing writes
  // ----------------------------------------------------------------
  fbdp_wr_state_t         ws_reg, ws_next;
  logic [2:0]             wcnt_reg, wcnt_next;
  logic [`FBDP_OFS_W-1:0] pofs_reg, pofs_next;
  logic [`FBDP_ADDR_W-1:0] addr_next;
  logic [`FBDP_DATA_W-1:0] dout_next;
  logic                   doe_b_next, cs_b_next, rd_b_next, wr_b_next;
  logic                   rd_on;
  logic [`FBDP_OFS_W-1:0] pix_ofs;

  // page base, word address counts from bit 1 of the byte address
  function automatic logic [`FBDP_ADDR_W-1:0] page_base(
    input logic [1:0] pg);
    logic [`FBDP_ADDR_W+1:0] prod;
    prod = `FBDP_PAGE_WORDS * pg;
    page_base = prod[`FBDP_ADDR_W-1:0];
  endfunction

  always_comb
  begin
    ws_next    = ws_reg;
    wcnt_next  = wcnt_reg;
    pofs_next  = pofs_reg;
    addr_next  = o_fb_word_addr;
    dout_next  = o_fb_data_bus;
    doe_b_next = 1'b1;
    cs_b_next  = 1'b1;
    rd_b_next  = 1'b1;
    wr_b_next  = 1'b1;
    wr_done    = 1'b0;
    pix_ofs    = tm_frame ? '0 : pofs_reg;
    // reads only while the looped-back request is seen
    rd_on      = tm_act && req_f;
    case (ws_reg)
      FBDP_WS_IDLE:
      begin
        if (rd_on)
        begin
          cs_b_next = 1'b0;
          rd_b_next = 1'b0;
        end
        // a pending write starts only on a blank dot
        if (tm_tick && tm_wok && pend_reg && !rd_on)
        begin
          ws_next    = FBDP_WS_SETUP;
          addr_next  = page_base(wpage_reg) +
                       {{(`FBDP_ADDR_W-`FBDP_OFS_W){1'b0}}, dofs_reg};
          dout_next  = ddata_reg;
          doe_b_next = 1'b0;
          cs_b_next  = 1'b0;
        end
      end
      FBDP_WS_SETUP:
      begin
        ws_next    = FBDP_WS_PULSE;
        wcnt_next  = 3'(WP_CYC - 1);
        doe_b_next = 1'b0;
        cs_b_next  = 1'b0;
        wr_b_next  = 1'b0;
      end
      FBDP_WS_PULSE:
      begin
        doe_b_next = 1'b0;
        cs_b_next  = 1'b0;
        wr_b_next  = 1'b0;
        wcnt_next  = wcnt_reg - 3'h1;
        if (wcnt_reg == 3'h0)
        begin
          ws_next   = FBDP_WS_HOLD;
          wr_b_next = 1'b1;
        end
      end
      FBDP_WS_HOLD:
      begin
        ws_next = FBDP_WS_IDLE;
        wr_done = 1'b1;
      end
      default:
        ws_next = FBDP_WS_IDLE;
    endcase
    // one pixel word per active dot, page switch at frame start
    if (tm_tick && tm_act)
    begin
      addr_next = page_base(dlive_next) +
                  {{(`FBDP_ADDR_W-`FBDP_OFS_W){1'b0}}, pix_ofs};
      pofs_next = pix_ofs + 1'b1;
    end
    else if (tm_frame)
      pofs_next = '0;
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ws_reg         <= FBDP_WS_IDLE;
      wcnt_reg       <= 3'h0;
      pofs_reg       <= '0;
      o_fb_word_addr <= '0;
      o_fb_data_bus  <= '0;
      o_fb_data_oe_b <= 1'b1; // sram owns the bus for pixels
      o_fb_cs_b      <= 1'b1;
      o_fb_rd_b      <= 1'b1;
      o_fb_wr_b      <= 1'b1;
      o_fb_ctl_oe_b  <= 1'b1;
    end
    else
    begin
      ws_reg         <= ws_next;
      wcnt_reg       <= wcnt_next;
      pofs_reg       <= pofs_next;
      o_fb_word_addr <= addr_next;
      o_fb_data_bus  <= dout_next;
      o_fb_data_oe_b <= doe_b_next;
      o_fb_cs_b      <= cs_b_next;
      o_fb_rd_b      <= rd_b_next;
      o_fb_wr_b      <= wr_b_next;
      o_fb_ctl_oe_b  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // panel drive
  // ----------------------------------------------------------------
  logic dot_clk_next;
  // high select: rise at dot start, fall mid-dot for sampling
  assign dot_clk_next = tm_hi ^ ~pol_f;

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_dot_clk            <= 1'b0;
      o_hsync_b            <= 1'b1;
      o_vsync_b            <= 1'b1;
      o_pixel_valid        <= 1'b0;
      o_display_period_out <= 1'b0;
      o_hmirror            <= `FBDP_MIRROR_RST;
      o_vflip              <= `FBDP_FLIP_RST;
    end
    else
    begin
      o_dot_clk            <= dot_clk_next;
      o_hsync_b            <= tm_hs_b;
      o_vsync_b            <= tm_vs_b;
      o_pixel_valid        <= tm_act;
      o_display_period_out <= tm_act;
      o_hmirror            <= mirror_reg;
      o_vflip              <= flip_reg;
    end
  end

endmodule

// ---- dv/fbdp_top_asserts.sv ----
// Purpose: port checks of the display path
// Assumes: request looped back, one-dot line sync, eight-clock dot
// Notes:   bound from the bench top file
`timescale 1ns/1ps
`include "fbdp_defines.svh"
module fbdp_top_asserts
#(
  parameter int DOT_DIV = 40
)
(
  input wire logic                    i_clk,
  input wire logic                    i_rst_b,
  input wire logic [`FBDP_ADDR_W-1:0] o_fb_word_addr,
  input wire logic [`FBDP_DATA_W-1:0] o_fb_data_bus,
  input wire logic                    o_fb_data_oe_b,
  input wire logic                    o_fb_cs_b,
  input wire logic                    o_fb_rd_b,
  input wire logic                    o_fb_wr_b,
  input wire logic                    o_fb_ctl_oe_b,
  input wire logic                    i_display_xfer_req,
  input wire logic                    o_display_period_out,
  input wire logic                    o_dot_clk,
  input wire logic                    o_hsync_b,
  input wire logic                    o_vsync_b,
  input wire logic                    o_pixel_valid
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic       dq_reg;
  logic       seen_reg;
  logic       seen_next;
  // ----------------------------------------------------------------
  // dot clock period counter
  // ----------------------------------------------------------------
  always_comb
  begin
    cnt_next  = (o_dot_clk && !dq_reg) ? 8'h00 : cnt_reg + 8'h01;
    seen_next = seen_reg | (o_dot_clk & ~dq_reg);
  end
  // counter registers
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      cnt_reg  <= 8'h00;
      dq_reg   <= 1'b0;
      seen_reg <= 1'b0;
    end
    else
    begin
      cnt_reg  <= cnt_next;
      dq_reg   <= o_dot_clk;
      seen_reg <= seen_next;
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_no_wr_display: assert property ((o_display_period_out ||
    i_display_xfer_req) |-> o_fb_wr_b) else $error("write in display");
  a_pv_equals_dp: assert property (o_pixel_valid ==
    o_display_period_out) else $error("enable differs from period");
  a_read_follows: assert property ($rose(o_display_period_out) |->
    ##[1:8] (!o_fb_rd_b && !o_fb_cs_b)) else $error("no display read");
  a_wr_pulse_len: assert property ($fell(o_fb_wr_b) |->
    (!o_fb_wr_b && !o_fb_cs_b)[*3] ##1 o_fb_wr_b) else $error("bad pulse");
  a_wr_stable: assert property (!o_fb_wr_b |-> $stable(o_fb_word_addr)
    && $stable(o_fb_data_bus)) else $error("write lines moved");
  a_no_contention: assert property (!o_fb_data_oe_b |-> o_fb_rd_b)
    else $error("bus driven during read");
  a_ctl_driven: assert property ($past(i_rst_b) |-> !o_fb_ctl_oe_b)
    else $error("control pins released");
  a_dot_period: assert property ((o_dot_clk && !dq_reg && seen_reg) |->
    cnt_reg == DOT_DIV - 1) else $error("dot period wrong");
  a_hsync_width: assert property ($fell(o_hsync_b) |->
    !o_hsync_b[*8] ##1 o_hsync_b) else $error("line sync width");
  a_sync_blank: assert property ((!o_hsync_b || !o_vsync_b) |->
    !o_display_period_out) else $error("period during sync");
  a_addr_range: assert property (!o_fb_cs_b |->
    o_fb_word_addr < 18'h38400) else $error("address past pages");
endmodule

// ---- dv/fbdp_mem_model.sv ----
// Purpose: frame buffer sram and panel loop-back
// Assumes: pins already resolved against pull-ups
// Notes:   released data bus shows the inverse of the last word
`timescale 1ns/1ps
module fbdp_mem_model
(
  input  wire logic        i_cs_b,
  input  wire logic        i_oe_b,
  input  wire logic        i_we_b,
  input  wire logic [17:0] i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_period,
  output logic             o_req,
  output logic      [15:0] o_rdata
);
  logic [15:0] mem [bit [17:0]];
  logic [15:0] last = 16'h0000;
  // period output wired back to the request pin
  assign o_req = i_period;
  // word lands at the rising edge of the write strobe
  always @(posedge i_we_b)
  begin
    if (!i_cs_b) mem[i_addr] = i_wdata;
  end
  // read drive while selected and output enabled
  always @(i_cs_b, i_oe_b, i_addr)
  begin
    if (!i_cs_b && !i_oe_b)
    begin
      last    = mem.exists(i_addr) ? mem[i_addr] : ~i_addr[15:0];
      o_rdata = last;
    end
    else o_rdata = ~last;
  end
endmodule

// ---- dv/frame_buffer_display_path_tb.sv ----
// Purpose: self-checking bench of the display path
// Assumes: small panel, frame of 432 clocks
// Notes:   pixel words compared with a shadow of drawn words
`timescale 1ns/1ps
module frame_buffer_display_path_tb;
  localparam int DOT_DIV = 8;
  localparam int PW = 76800;
  logic i_clk, i_rst_b, i_wr, i_rd;
  logic [3:0] i_addr;
  logic [31:0] i_wdata, o_rdata, s, v;
  logic [17:0] o_fb_word_addr, base = 18'h0;
  logic [15:0] o_fb_data_bus, i_fb_data_bus, mout;
  logic o_fb_data_oe_b, o_fb_cs_b, o_fb_rd_b, o_fb_wr_b, o_fb_ctl_oe_b;
  logic i_display_xfer_req, o_display_period_out, o_dot_clk, o_hsync_b;
  logic o_vsync_b, o_pixel_valid, o_hmirror, o_vflip, c0, c1;
  logic i_dot_clk_pol_sel, rd_q = 1'b1, mon = 1'b0;
  logic [15:0] shadow [bit [17:0]];
  int errors = 0, comparisons = 0, line = 0, seed;
  // data wire and pulled-up control pins
  assign i_fb_data_bus = o_fb_data_oe_b ? mout : o_fb_data_bus;
  fbdp_top #(.H_ACT(4), .H_FP(2), .H_SYNC(1), .H_BP(2), .V_ACT(3),
    .V_FP(1), .V_SYNC(1), .V_BP(1), .DOT_DIV(DOT_DIV)) dut (.i_clk,
    .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_fb_word_addr,
    .i_fb_data_bus, .o_fb_data_bus, .o_fb_data_oe_b, .o_fb_cs_b,
    .o_fb_rd_b, .o_fb_wr_b, .o_fb_ctl_oe_b, .i_display_xfer_req,
    .o_display_period_out, .o_dot_clk, .o_hsync_b, .o_vsync_b,
    .o_pixel_valid, .o_hmirror, .o_vflip, .i_dot_clk_pol_sel);
  fbdp_mem_model u_mem (.i_cs_b(o_fb_ctl_oe_b | o_fb_cs_b),
    .i_oe_b(o_fb_ctl_oe_b | o_fb_rd_b), .i_we_b(o_fb_ctl_oe_b | o_fb_wr_b),
    .i_addr(o_fb_word_addr), .i_wdata(i_fb_data_bus),
    .i_period(o_display_period_out), .o_req(i_display_xfer_req),
    .o_rdata(mout));
  // clock
  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic draw(input int pg, input int ofs, input logic [15:0] d);
    logic [31:0] st;
    logic [17:0] wa;
    int n;
    wa = 18'(pg * PW + ofs);
    n = 0;
    wreg(4'h8, {16'h0, d});
    do
    begin
      rreg(4'hC, st);
      n++;
    end while (st[0] !== 1'b0 && n < 600);
    chk(u_mem.mem.exists(wa) ? u_mem.mem[wa] : 16'hXXXX, d);
    shadow[wa] = d;
  endtask
  task automatic end_sim;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // display fetch monitor: line start address and pixel on the bus
  always @(posedge i_clk)
  begin
    rd_q <= o_fb_rd_b;
    if (!o_vsync_b) line <= 0;
    if (mon && rd_q && !o_fb_rd_b)
    begin
      chk(o_fb_word_addr, base + 18'(line * 4));
      line <= line + 1;
    end
    if (mon && !o_fb_rd_b && shadow.exists(o_fb_word_addr))
      chk(i_fb_data_bus, shadow[o_fb_word_addr]);
  end
  // watchdog
  initial
  begin
    #200000;
    errors++;
    end_sim();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    seed = 32'h0a44;
    i_rst_b <= 1'b0;
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    i_addr <= 4'h0;
    i_wdata <= 32'h0;
    i_dot_clk_pol_sel <= 1'b1;
    repeat (2) @(posedge i_clk);
    chk({o_fb_ctl_oe_b, o_fb_cs_b, o_fb_rd_b, o_fb_wr_b, o_hmirror,
      o_vflip}, 6'h3D);
    i_rst_b <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      v = {26'h0, 2'(($random(seed) & 32'h7FFF) % 3),
        2'(($random(seed) & 32'h7FFF) % 3), 2'(i)};
      wreg(4'h0, v);
      @(posedge i_clk);
      #1 chk({o_vflip, o_hmirror}, i);
      rreg(4'h0, s);
      chk(s[5:0], v[5:0]);
    end
    wreg(4'h0, 32'h0000003F);
    rreg(4'h0, s);
    chk(s[5:0], {v[5:2], 2'h3});
    // drawing: wrap at the page end, refused offset, random offsets
    for (int k = 0; k < 8; k++)
    begin
      wreg(4'h0, 32'(k % 3) << 4);
      if (k == 0) wreg(4'h4, 32'd76799);
      if (k == 2) wreg(4'h4, 32'd76800);
      if (k > 2) wreg(4'h4, 32'(($random(seed) & 32'h7FFF) % 12));
      draw(k % 3, k == 0 ? 76799 : (k < 3 ? k - 1 :
        int'(dut.i_wdata[16:0])), 16'($random(seed)));
    end
    // display page walk
    for (int p = 0; p < 3; p++)
    begin
      wreg(4'h0, 32'(p) << 2);
      base = 18'(p * PW);
      repeat (2) @(posedge o_vsync_b);
      mon = 1'b1;
      @(posedge o_vsync_b);
      mon = 1'b0;
    end
    // dot clock level at the first active dot under both polarities;
    // strap moves only under reset, a live flip would cut a dot short
    @(posedge o_display_period_out);
    #1 c1 = o_dot_clk;
    // second reset in mid-run
    @(posedge i_clk);
    i_rst_b <= 1'b0;
    i_dot_clk_pol_sel <= 1'b0;
    #1 chk({o_fb_ctl_oe_b, o_hmirror, o_vflip}, 3'h5);
    @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(posedge o_display_period_out);
    #1 c0 = o_dot_clk;
    chk(c0, !c1);
    repeat (20) @(posedge i_clk);
    end_sim();
  end
endmodule
bind fbdp_top fbdp_top_asserts #(.DOT_DIV(DOT_DIV)) u_chk (.i_clk,
  .i_rst_b, .o_fb_word_addr, .o_fb_data_bus, .o_fb_data_oe_b, .o_fb_cs_b,
  .o_fb_rd_b, .o_fb_wr_b, .o_fb_ctl_oe_b, .i_display_xfer_req,
  .o_display_period_out, .o_dot_clk, .o_hsync_b, .o_vsync_b,
  .o_pixel_valid);
